// ===== rtl/ulf_core.sv
// What this block does
// R1: Format bit 7 set maps divisor latch and enhanced feature register in.
// R2: While bit 7 is set, the general registers cannot be reached.
// R3: Bit 6 set holds the serial output low until cleared.
// R4: Bit 3 enables a parity bit on transmit and its check on receive.
// R5: Bit 4 chooses even (one) or odd (zero) parity for both directions.
// R6: Bits 5 and 3 set force parity to the inverse of bit 4.
// R7: Bit 2 selects stop length with word length; reset value zero.
// R8: Stop is one bit, or 1.5 for five bits, else two bits.
// R9: Bits 1-0 set character length for both directions; reset zero.
// R10: Word length codes 00 to 11 give 5 to 8 data bits.
// R11: The format register reads zero after reset.
// R12: Receive parity mismatch flags a parity error for that character.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ulf_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Serial line
    input wire logic rx_serial,
    output logic tx_serial
);
    import ulf_pkg::*;

    typedef struct packed {
        ulf_fmt_t line_format_control;
        logic [15:0] div;
        logic [7:0] efr;
        logic waitreq;
        logic [31:0] rdata;
        logic tx_pin;
        logic tx_go;
        logic [7:0] tx_data;
        logic [2:0] rx_sync;
        logic rx_s;
        ulf_state_t rx_state;
        logic [15:0] rx_cnt;
        logic [2:0] rx_halves;
        logic [3:0] rx_bits;
        logic [7:0] rx_shift;
        logic rx_par;
        logic [7:0] rx_data;
        logic rx_ready;
        logic rx_perr;
        logic rx_ferr;
    } ulf_core_st_t;

    ulf_core_st_t st;
    ulf_core_st_t next_st;
    logic tx_line;
    logic tx_busy;
    logic acc;
    logic rx_tick;
    logic rx_bit_end;
    logic rx_done;
    logic rx_perr_now;
    logic [31:0] rd_mux;

    assign avs_readdata = st.rdata;
    assign avs_waitrequest = st.waitreq;
    assign tx_serial = st.tx_pin;

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    ulf_tx u_tx (
        .core_clk(core_clk),
        .rst(rst),
        .start(st.tx_go),
        .data(st.tx_data),
        .fmt(st.line_format_control),
        .half_div(st.div),
        .txd(tx_line),
        .busy(tx_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data selection, banked by the divisor access bit
    always_comb begin
        rd_mux = 32'h0;
        if (avs_address == OFS_FORMAT) begin
            rd_mux = {24'h0, st.line_format_control};
        end else if (st.line_format_control.dlab) begin // [R1] [R2]
            unique case (avs_address)
                OFS_DIV_LO: rd_mux = {24'h0, st.div[7:0]};
                OFS_DIV_HI: rd_mux = {24'h0, st.div[15:8]};
                OFS_EFR: rd_mux = {24'h0, st.efr};
                default: rd_mux = 32'h0;
            endcase
        end else begin
            unique case (avs_address)
                OFS_DATA: rd_mux = {24'h0, st.rx_data};
                OFS_STATUS: rd_mux = {28'h0, tx_busy, st.rx_ferr, st.rx_perr, st.rx_ready};
                default: rd_mux = 32'h0;
            endcase
        end
    end

    assign acc = (avs_read || avs_write) && !st.waitreq;
    assign rx_tick = (st.rx_cnt == 16'h0);
    assign rx_bit_end = rx_tick && (st.rx_halves == 3'h0);
    assign rx_done = (st.rx_state == ULF_STOP) && rx_bit_end;
    assign rx_perr_now = st.line_format_control.pen
        && (st.rx_par != ulf_parity(st.rx_shift, st.line_format_control)); // [R12]

    ////////////////////////////////////////////////////////////////////////
    // Next state: bus slave, register file, break, receiver
    always_comb begin
        next_st = st;
        next_st.tx_go = 1'b0;
        next_st.waitreq = 1'b1;
        // One wait cycle, then answer
        if ((avs_read || avs_write) && st.waitreq) begin
            next_st.waitreq = 1'b0;
            next_st.rdata = rd_mux;
        end
        // Writes take effect on the answering edge
        if (acc && avs_write && avs_byteenable[0]) begin
            if (avs_address == OFS_FORMAT) begin
                next_st.line_format_control = ulf_fmt_t'(avs_writedata[7:0]);
            end else if (st.line_format_control.dlab) begin // [R1]
                unique case (avs_address)
                    OFS_DIV_LO: next_st.div[7:0] = avs_writedata[7:0];
                    OFS_DIV_HI: next_st.div[15:8] = avs_writedata[7:0];
                    OFS_EFR: next_st.efr = avs_writedata[7:0];
                    default: next_st.efr = st.efr;
                endcase
            end else if (avs_address == OFS_DATA && !tx_busy) begin // [R2]
                next_st.tx_data = avs_writedata[7:0];
                next_st.tx_go = 1'b1;
            end
        end
        // Reading received data clears its flags
        if (acc && avs_read && !st.line_format_control.dlab && avs_address == OFS_DATA) begin
            next_st.rx_ready = 1'b0;
            next_st.rx_perr = 1'b0;
            next_st.rx_ferr = 1'b0;
        end
        // Break forces the line low
        next_st.tx_pin = st.line_format_control.brk ? 1'b0 : tx_line; // [R3]
        // Input synchroniser, change accepted when stages two and three agree
        next_st.rx_sync = {st.rx_sync[1:0], rx_serial};
        if (st.rx_sync[1] == st.rx_sync[2])
            next_st.rx_s = st.rx_sync[2];
        // Receiver bit timing
        if (st.rx_state != ULF_IDLE) begin
            next_st.rx_cnt = rx_tick ? ulf_reload(st.div) : st.rx_cnt - 16'h1;
            if (rx_tick)
                next_st.rx_halves = st.rx_halves - 3'h1;
        end
        unique case (st.rx_state)
            ULF_IDLE: begin
                if (!st.rx_s) begin
                    next_st.rx_state = ULF_START;
                    next_st.rx_cnt = ulf_reload(st.div);
                    next_st.rx_halves = 3'h0;
                end
            end
            ULF_START: begin
                if (rx_bit_end) begin
                    next_st.rx_state = st.rx_s ? ULF_IDLE : ULF_DATA;
                    next_st.rx_halves = HALVES_BIT - 3'h1;
                    next_st.rx_bits = 4'h0;
                    next_st.rx_shift = 8'h0;
                end
            end
            ULF_DATA: begin
                if (rx_bit_end) begin
                    next_st.rx_halves = HALVES_BIT - 3'h1;
                    next_st.rx_shift[3'(st.rx_bits)] = st.rx_s;
                    next_st.rx_bits = st.rx_bits + 4'h1;
                    if (st.rx_bits == ulf_bits(st.line_format_control) - 4'h1) // [R9] [R10]
                        next_st.rx_state = st.line_format_control.pen ? ULF_PAR : ULF_STOP; // [R4]
                end
            end
            ULF_PAR: begin
                if (rx_bit_end) begin
                    next_st.rx_par = st.rx_s;
                    next_st.rx_state = ULF_STOP;
                    next_st.rx_halves = HALVES_BIT - 3'h1;
                end
            end
            ULF_STOP: begin
                if (rx_bit_end) begin
                    next_st.rx_state = ULF_IDLE;
                    next_st.rx_data = st.rx_shift;
                    next_st.rx_ready = 1'b1;
                    next_st.rx_perr = rx_perr_now; // [R5] [R6] [R12]
                    next_st.rx_ferr = !st.rx_s;
                end
            end
            default: next_st.rx_state = ULF_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
            st.line_format_control <= ulf_fmt_t'(FORMAT_RESET); // [R11]
            st.div <= DIV_RESET;
            st.efr <= EFR_RESET;
            st.waitreq <= 1'b1;
            st.tx_pin <= 1'b1;
            st.rx_sync <= 3'h7;
            st.rx_s <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_req_seen;
        (avs_read || avs_write) && st.waitreq;
    endsequence
    sequence s_answer;
        !st.waitreq ##1 st.waitreq;
    endsequence

    chk_bus_answer: assert property (s_req_seen |=> s_answer) // Avalon-MM answer timing, the implementer's own choice
        else $error("bus answer not after one wait cycle");
    chk_reset_clear: assert property ($fell(rst) |-> // [R11]
        st.line_format_control == FORMAT_RESET)
        else $error("format not zero after reset");
    chk_divisor_map: assert property (s_req_seen and avs_read && avs_address == OFS_DIV_LO
        && st.line_format_control.dlab |=> st.rdata == {24'h0, st.div[7:0]}) // [R1]
        else $error("divisor not mapped");
    chk_general_block: assert property (acc && avs_write && avs_address == OFS_DATA
        && st.line_format_control.dlab |=> !st.tx_go) // [R2]
        else $error("general register reached with divisor access");
    chk_break_low: assert property (st.line_format_control.brk [*2] |-> !tx_serial) // [R3]
        else $error("break not driven");
    chk_parity_flag: assert property (rx_done && rx_perr_now |=> st.rx_perr && st.rx_ready) // [R12]
        else $error("parity error not flagged");
endmodule // ulf_core
`default_nettype wire

// ===== rtl/ulf_pkg.sv
package ulf_pkg;
    // Register byte offsets, general set (divisor access clear); efr is reached only with divisor access set
    localparam logic [3:0] OFS_DATA = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_FORMAT = 4'h8;
    localparam logic [3:0] OFS_EFR = 4'hc;
    // Register byte offsets while divisor access is set
    localparam logic [3:0] OFS_DIV_LO = 4'h0;
    localparam logic [3:0] OFS_DIV_HI = 4'h4;
    // Reset values
    localparam logic [7:0] FORMAT_RESET = 8'h00;
    localparam logic [15:0] DIV_RESET = 16'h0001;
    localparam logic [7:0] EFR_RESET = 8'h00;
    // Frame timing in half bit times, and the word length base in data bits
    localparam logic [2:0] HALVES_BIT = 3'h2;
    localparam logic [2:0] HALVES_STOP_1 = 3'h2;
    localparam logic [2:0] HALVES_STOP_15 = 3'h3;
    localparam logic [2:0] HALVES_STOP_2 = 3'h4;
    localparam logic [3:0] WLEN_BASE = 4'h5;

    // Line format register layout, bit 7 first
    typedef struct packed {
        logic dlab;
        logic brk;
        logic stick;
        logic even;
        logic pen;
        logic stop2;
        logic [1:0] wlen;
    } ulf_fmt_t;

    typedef enum logic [2:0] {
        ULF_IDLE = 3'b000,
        ULF_START = 3'b001,
        ULF_DATA = 3'b010,
        ULF_PAR = 3'b011,
        ULF_STOP = 3'b100
    } ulf_state_t;

    // Data bits per character, 5 to 8
    function automatic logic [3:0] ulf_bits(input ulf_fmt_t f);
        return WLEN_BASE + {2'h0, f.wlen};
    endfunction

    // Stop length in half bits
    function automatic logic [2:0] ulf_stop_halves(input ulf_fmt_t f);
        if (!f.stop2)
            return HALVES_STOP_1;
        return (f.wlen == 2'h0) ? HALVES_STOP_15 : HALVES_STOP_2;
    endfunction

    // Parity bit for the used data bits
    function automatic logic ulf_parity(input logic [7:0] d, input ulf_fmt_t f);
        logic [7:0] m;
        m = 8'hff >> (4'h8 - ulf_bits(f));
        if (f.stick)
            return ~f.even;
        return f.even ? ^(d & m) : ~^(d & m);
    endfunction

    // Reload value of the half bit counter
    function automatic logic [15:0] ulf_reload(input logic [15:0] div);
        return (div == 16'h0) ? 16'h0 : div - 16'h1;
    endfunction
endpackage

// ===== rtl/ulf_tx.sv
`timescale 1ns/1ps
`default_nettype none
module ulf_tx (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Character request
    input wire logic start,
    input wire logic [7:0] data,
    input wire ulf_pkg::ulf_fmt_t fmt,
    input wire logic [15:0] half_div,
    // Serial side
    output logic txd,
    output logic busy
);
    import ulf_pkg::*;

    typedef struct packed {
        ulf_state_t state;
        ulf_fmt_t fmt;
        logic [7:0] data;
        logic [15:0] cnt;
        logic [2:0] halves;
        logic [3:0] bits;
        logic txd;
        logic busy;
    } ulf_tx_st_t;

    ulf_tx_st_t st;
    ulf_tx_st_t next_st;
    logic tick;
    logic bit_end;

    assign txd = st.txd;
    assign busy = st.busy;
    assign tick = (st.cnt == 16'h0);
    assign bit_end = tick && (st.halves == 3'h0);

    // Frame sequencer: start, data, optional parity, stop
    always_comb begin
        next_st = st;
        if (st.state != ULF_IDLE) begin
            next_st.cnt = tick ? ulf_reload(half_div) : st.cnt - 16'h1;
            if (tick)
                next_st.halves = st.halves - 3'h1;
        end
        unique case (st.state)
            ULF_IDLE: begin
                if (start) begin
                    next_st.state = ULF_START;
                    next_st.fmt = fmt;
                    next_st.data = data;
                    next_st.cnt = ulf_reload(half_div);
                    next_st.halves = HALVES_BIT - 3'h1;
                    next_st.txd = 1'b0;
                    next_st.busy = 1'b1;
                end
            end
            ULF_START: begin
                if (bit_end) begin
                    next_st.state = ULF_DATA;
                    next_st.bits = 4'h0;
                    next_st.halves = HALVES_BIT - 3'h1;
                    next_st.txd = st.data[0];
                end
            end
            ULF_DATA: begin
                if (bit_end) begin
                    next_st.halves = HALVES_BIT - 3'h1;
                    if (st.bits == ulf_bits(st.fmt) - 4'h1) begin // [R9] [R10]
                        if (st.fmt.pen) begin // [R4]
                            next_st.state = ULF_PAR;
                            next_st.txd = ulf_parity(st.data, st.fmt); // [R5] [R6]
                        end else begin
                            next_st.state = ULF_STOP;
                            next_st.txd = 1'b1;
                            next_st.halves = ulf_stop_halves(st.fmt) - 3'h1; // [R7] [R8]
                        end
                    end else begin
                        next_st.bits = st.bits + 4'h1;
                        next_st.txd = st.data[3'(st.bits + 4'h1)];
                    end
                end
            end
            ULF_PAR: begin
                if (bit_end) begin
                    next_st.state = ULF_STOP;
                    next_st.txd = 1'b1;
                    next_st.halves = ulf_stop_halves(st.fmt) - 3'h1; // [R7] [R8]
                end
            end
            ULF_STOP: begin
                if (bit_end) begin
                    next_st.state = ULF_IDLE;
                    next_st.busy = 1'b0;
                end
            end
            default: next_st.state = ULF_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
            st.txd <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_no_parity_slot: assert property ((st.state == ULF_PAR) |-> st.fmt.pen) // [R4]
        else $error("parity slot sent with parity off");
    chk_parity_value: assert property ((st.state == ULF_PAR) |-> st.txd == ulf_parity(st.data, st.fmt)) // [R5] [R6]
        else $error("wrong parity bit");
    chk_word_length: assert property ((st.state == ULF_DATA && next_st.state != ULF_DATA) |-> st.bits == ulf_bits(st.fmt) - 4'h1) // [R10]
        else $error("wrong data bit count");
    chk_stop_length: assert property ($rose(st.state == ULF_STOP) |-> st.halves == ulf_stop_halves(st.fmt) - 3'h1) // [R8]
        else $error("wrong stop length");
endmodule // ulf_tx
`default_nettype wire

// ===== verification/ulf_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ulf_core_tb;
    import ulf_pkg::*;

    // Format, character and the parity bit that format must give
    typedef struct packed {
        logic [7:0] fmt;
        logic [7:0] data;
        logic par;
    } ulf_row_t;

    localparam int HALF_BITS = 4;
    localparam ulf_row_t ROWS [9] = '{
        '{8'h00, 8'hf5, 1'b0}, '{8'h0d, 8'h2c, 1'b0}, '{8'h1a, 8'h7f, 1'b1},
        '{8'h1e, 8'h57, 1'b1}, '{8'h0b, 8'ha5, 1'b1}, '{8'h2b, 8'h3c, 1'b1},
        '{8'h3b, 8'hc3, 1'b0}, '{8'h34, 8'h0a, 1'b0}, '{8'h1b, 8'h01, 1'b1}};

    logic core_clk, rst, avs_read, avs_write, rx_serial, avs_waitrequest, tx_serial;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [7:0] gd, m;
    logic gp, gs;
    int n_fail, check_count, cycles, n, lo;

    ////////////////////////////////////////////////////////////////////////////////
    // Design and far end
    ulf_core i_dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_serial(rx_serial), .tx_serial(tx_serial));
    ulf_remote_model #(.HALF(HALF_BITS)) i_far (.core_clk(core_clk), .line_in(tx_serial),
        .line_out(rx_serial));

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_fail++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write <= we;
        avs_read <= ~we;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // Compare and count
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Poll status until a character is ready
    task automatic wait_ready();
        int t;
        t = 0;
        rd = 32'h0;
        while (rd[0] !== 1'b1 && t < 40) begin
            bus(1'b0, OFS_STATUS, 8'h00, 4'h1, rd);
            t++;
        end
    endtask

    // Verdict and end of run
    task automatic give_verdict();
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_byteenable = 4'h1;
        avs_writedata = 32'h0;
        n_fail = 0;
        check_count = 0;
        cycles = 0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        // Reset state, hidden and unmapped places
        check("tx idle", 32'h1, {31'h0, tx_serial});
        bus(1'b0, OFS_FORMAT, 8'h00, 4'h1, rd);
        check("format reset", 32'h0, rd);
        bus(1'b0, OFS_EFR, 8'h00, 4'h1, rd);
        check("efr hidden", 32'h0, rd);
        bus(1'b0, 4'h2, 8'h00, 4'h1, rd);
        check("unmapped", 32'h0, rd);
        // Divisor access maps latch and efr in place of the general set
        bus(1'b1, OFS_FORMAT, 8'h80, 4'h1, rd);
        bus(1'b1, OFS_DIV_HI, 8'h12, 4'h1, rd);
        bus(1'b0, OFS_DIV_HI, 8'h00, 4'h1, rd);
        check("divisor high", 32'h12, rd);
        bus(1'b1, OFS_DIV_HI, 8'h00, 4'h1, rd);
        bus(1'b1, OFS_DIV_LO, HALF_BITS[7:0], 4'h1, rd);
        bus(1'b0, OFS_DIV_LO, 8'h00, 4'h1, rd);
        check("divisor low", HALF_BITS, rd);
        bus(1'b1, OFS_EFR, 8'h5a, 4'h1, rd);
        bus(1'b0, OFS_EFR, 8'h00, 4'h1, rd);
        check("efr", 32'h5a, rd);
        bus(1'b1, OFS_FORMAT, 8'h03, 4'h1, rd);
        bus(1'b0, OFS_EFR, 8'h00, 4'h1, rd);
        check("efr hidden again", 32'h0, rd);
        bus(1'b0, OFS_STATUS, 8'h00, 4'h1, rd);
        check("status back", 32'h0, rd);
        // Every format row: transmit, then receive the same character back
        foreach (ROWS[i]) begin
            bus(1'b1, OFS_FORMAT, ROWS[i].fmt, 4'h1, rd);
            bus(1'b0, OFS_FORMAT, 8'h00, 4'h1, rd);
            check("format", {24'h0, ROWS[i].fmt}, rd);
            n = 5 + int'(ROWS[i].fmt[1:0]);
            m = 8'hff >> (8 - n);
            bus(1'b1, OFS_DATA, ROWS[i].data, 4'h1, rd);
            bus(1'b0, OFS_STATUS, 8'h00, 4'h1, rd);
            check("tx busy", 32'h8, rd);
            i_far.recv(n, ROWS[i].fmt[3], gd, gp, gs);
            check("tx data", {24'h0, m & ROWS[i].data}, {24'h0, gd});
            if (ROWS[i].fmt[3]) begin
                check("tx parity", {31'h0, ROWS[i].par}, {31'h0, gp});
            end
            check("tx stop", 32'h1, {31'h0, gs});
            i_far.send(ROWS[i].data, n, ROWS[i].fmt[3], ROWS[i].par);
            wait_ready();
            check("rx status", 32'h1, rd);
            bus(1'b0, OFS_DATA, 8'h00, 4'h1, rd);
            check("rx data", {24'h0, m & ROWS[i].data}, rd);
        end
        // Wrong parity from the far end is flagged, then cleared by the data read
        i_far.send(8'h01, 8, 1'b1, 1'b0);
        wait_ready();
        check("parity error", 32'h3, rd);
        bus(1'b0, OFS_DATA, 8'h00, 4'h1, rd);
        bus(1'b0, OFS_STATUS, 8'h00, 4'h1, rd);
        check("flags cleared", 32'h0, rd);
        // Break holds the line low until cleared
        bus(1'b1, OFS_FORMAT, 8'h40, 4'h1, rd);
        repeat (3) @(posedge core_clk);
        lo = 0;
        repeat (16) begin
            @(posedge core_clk);
            lo += int'(tx_serial === 1'b0);
        end
        check("break low", 32'd16, lo);
        bus(1'b1, OFS_FORMAT, 8'h00, 4'h1, rd);
        repeat (3) @(posedge core_clk);
        check("break released", 32'h1, {31'h0, tx_serial});
        // Write with byte lane off is ignored
        bus(1'b1, OFS_FORMAT, 8'h55, 4'h0, rd);
        bus(1'b0, OFS_FORMAT, 8'h00, 4'h1, rd);
        check("lane off", 32'h0, rd);
        // Second reset in mid-run
        bus(1'b1, OFS_FORMAT, 8'h7f, 4'h1, rd);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        bus(1'b0, OFS_FORMAT, 8'h00, 4'h1, rd);
        check("format after reset", 32'h0, rd);
        check("tx after reset", 32'h1, {31'h0, tx_serial});
        give_verdict();
    end
endmodule // ulf_core_tb
`default_nettype wire

// ===== verification/ulf_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
module ulf_remote_model #(
    parameter int HALF = 4
) (
    // Clock
    input wire logic core_clk,
    // Serial lines seen from the far end
    input wire logic line_in,
    output logic line_out
);
    // Idle line is high between frames
    initial line_out = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // Send one frame; the caller supplies the parity bit, so it may be wrong on purpose
    task automatic send(input logic [7:0] d, input int n, input logic pen, input logic par);
        line_out <= 1'b0;
        repeat (2 * HALF) @(posedge core_clk);
        for (int i = 0; i < n; i++) begin
            line_out <= d[i];
            repeat (2 * HALF) @(posedge core_clk);
        end
        if (pen) begin
            line_out <= par;
            repeat (2 * HALF) @(posedge core_clk);
        end
        line_out <= 1'b1;
        repeat (2 * HALF) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Take one frame, sampling each bit near its middle
    task automatic recv(input int n, input logic pen, output logic [7:0] d, output logic par,
                        output logic stp);
        int w;
        d = 8'h00;
        par = 1'b0;
        w = 0;
        while (line_in !== 1'b0 && w < 400) begin
            @(posedge core_clk);
            w++;
        end
        repeat (HALF) @(posedge core_clk);
        for (int i = 0; i < n; i++) begin
            repeat (2 * HALF) @(posedge core_clk);
            d[i] = line_in;
        end
        if (pen) begin
            repeat (2 * HALF) @(posedge core_clk);
            par = line_in;
        end
        repeat (2 * HALF) @(posedge core_clk);
        stp = line_in;
    endtask
endmodule // ulf_remote_model
`default_nettype wire
